// ===== cbbl_params.svh
// Purpose: Shared constants of the bus byte-lane handshake controller.
// Assumes: Included by bare name from the design files.
// Notes:   Definitions only.
`ifndef CBBL_PARAMS_SVH
`define CBBL_PARAMS_SVH
`define CBBL_SIZE_LONG  2'h0
`define CBBL_SIZE_BYTE  2'h1
`define CBBL_SIZE_WORD  2'h2
`define CBBL_SIZE_3BYTE 2'h3
`define CBBL_REM_LONG   3'h4
`define CBBL_ALIGN_LONG 2'h0
`define CBBL_MIN_CYCLE_CLKS 3
`define CBBL_RESP_W     33
`endif

// ===== cbbl_pkg.sv
// Purpose: Types of the bus byte-lane handshake controller.
// Assumes: Nothing.
// Notes:   State codes are written out.
package cbbl_pkg;
    typedef enum logic [2:0] {
        CBBL_IDLE  = 3'h0,
        CBBL_START = 3'h1,
        CBBL_WAIT  = 3'h2,
        CBBL_TERM  = 3'h3,
        CBBL_RESP  = 3'h4
    } cbbl_state_type;
    typedef enum logic [1:0] {
        CBBL_PORT8  = 2'h0,
        CBBL_PORT16 = 2'h1,
        CBBL_PORT32 = 2'h2
    } cbbl_port_type;
endpackage

// ===== cbbl_resp_buf.sv
// Purpose: Two-entry buffer for completed transfers.
// Assumes: Synchronous consumer with valid and ready.
// Notes:   All outputs are flip-flops; a stall loses no word.
`timescale 1ns/100ps
`default_nettype none
module cbbl_resp_buf #(
    parameter int W = 33
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    logic         main_v_q, main_v_d, skid_v_q, skid_v_d, rdy_d;
    logic [W-1:0] main_q, main_d, skid_q, skid_d;

    always_comb begin
        main_v_d = main_v_q;
        main_d   = main_q;
        skid_v_d = skid_v_q;
        skid_d   = skid_q;
        if (skid_v_q) begin
            if (out_ready) begin
                main_d   = skid_q;
                skid_v_d = 1'b0;
            end
        end else if (in_valid) begin
            if (!main_v_q || out_ready) begin
                main_d   = in_data;
                main_v_d = 1'b1;
            end else begin
                skid_d   = in_data;
                skid_v_d = 1'b1;
            end
        end else if (out_ready) begin
            main_v_d = 1'b0;
        end
        rdy_d = !skid_v_d;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            main_v_q <= 1'b0;
            skid_v_q <= 1'b0;
            main_q   <= '0;
            skid_q   <= '0;
            in_ready <= 1'b0;
        end else begin
            main_v_q <= main_v_d;
            skid_v_q <= skid_v_d;
            main_q   <= main_d;
            skid_q   <= skid_d;
            in_ready <= rdy_d;
        end
    end

    assign out_valid = main_v_q;
    assign out_data  = main_q;
endmodule
`default_nettype wire

// ===== cbbl_bus_ctrl.sv
// Purpose: External asynchronous bus controller with dynamic sizing.
// Assumes: Bus inputs are synchronous to clk; one operation at a time.
// Notes:   Results leave through a two-entry buffer.
// Functional notes
// - Size code 01 byte, 10 word, 11 three, 00 long.
// - Writes drive all four data lanes.
// - Move size-code bytes, capped by port and alignment.
// - 32-bit port byte lanes follow low address.
// - Cache hit aborts fetch cycle before address strobe.
// - Early start pulses; not a committed cycle.
// - Instruction prefetches at most every other clock.
// - Address strobe starts cycle; data strobe marks data.
// - No upper limit on acknowledge delay.
// - Cycle lasts three clocks minimum, whole wait states.
// - Late bus error, alone or with halt, after acknowledge honoured.
// - Instruction fetch is long word at aligned address.
`timescale 1ns/100ps
`default_nettype none
`include "cbbl_params.svh"
module cbbl_bus_ctrl
    import cbbl_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        req_valid,
    output logic             req_ready,
    input  wire logic [31:0] req_addr,
    input  wire logic [1:0]  req_size,
    input  wire logic        req_write,
    input  wire logic [31:0] req_wdata,
    input  wire logic        req_fetch,
    input  wire logic        cache_hit,
    output logic             resp_valid,
    input  wire logic        resp_ready,
    output logic [31:0]      resp_data,
    output logic             resp_error,
    output logic [31:0]      bus_addr,
    output logic             size_code_hi,
    output logic             size_code_lo,
    output logic             bus_read,
    output logic             addr_strobe_n,
    output logic             data_strobe_n,
    output logic             early_cycle_start_n,
    output logic             operand_cycle_start_n,
    output logic [31:0]      data_out,
    output logic             data_oe,
    input  wire logic [31:0] data_in,
    input  wire logic        ack_port_hi_n,
    input  wire logic        ack_port_lo_n,
    input  wire logic        bus_error_n,
    input  wire logic        halt_n
);
    cbbl_state_type state_q, state_d;
    cbbl_port_type  port_q, port_d;
    logic [31:0]    addr_q, addr_d, wbuf_q, wbuf_d, rbuf_q, rbuf_d, acc;
    logic [31:0]    dout_d;
    logic [2:0]     rem_q, rem_d, cap, nmov;
    logic [1:0]     lane0, lane;
    logic           write_q, write_d, fetch_q, fetch_d, first_q, first_d;
    logic           err_q, err_d, as_d, ecs_d, ocs_d, oe_d, rdy_d;
    logic           buf_ready;

    // Slaves may answer on any lane, so write bytes are placed where
    // every port width finds its first byte without knowing the port.
    function automatic logic [31:0] wlanes(input logic [31:0] b,
                                           input logic [1:0]  off);
        logic [1:0]  idx;
        logic [31:0] r;
        r = '0;
        for (int j = 0; j < 4; j++) begin
            if (2'(j) >= off) idx = 2'(j) - off;
            else if (j == 1) idx = 2'h1 - {1'b0, off[0]};
            else idx = 2'h0;
            r[8*(3-j) +: 8] = b[8*(3-idx) +: 8];
        end
        return r;
    endfunction

    always_comb begin
        case (port_q)
            CBBL_PORT32: begin
                cap   = 3'h4 - {1'b0, addr_q[1:0]};
                lane0 = addr_q[1:0];
            end
            CBBL_PORT16: begin
                cap   = 3'h2 - {2'h0, addr_q[0]};
                lane0 = {1'b0, addr_q[0]};
            end
            default: begin
                cap   = 3'h1;
                lane0 = 2'h0;
            end
        endcase
        nmov = (rem_q < cap) ? rem_q : cap;
        acc  = rbuf_q;
        lane = lane0;
        for (int i = 0; i < 4; i++) begin
            lane = lane0 + 2'(i);
            if (3'(i) < nmov) acc = {acc[23:0], data_in[8*(3-lane) +: 8]};
        end
    end

    always_comb begin
        state_d = state_q;
        port_d  = port_q;
        addr_d  = addr_q;
        rem_d   = rem_q;
        wbuf_d  = wbuf_q;
        rbuf_d  = rbuf_q;
        write_d = write_q;
        fetch_d = fetch_q;
        first_d = first_q;
        err_d   = err_q;
        case (state_q)
            CBBL_IDLE: if (req_valid && req_ready) begin
                state_d = CBBL_START;
                fetch_d = req_fetch;
                first_d = 1'b1;
                err_d   = 1'b0;
                rbuf_d  = '0;
                if (req_fetch) begin
                    addr_d  = {req_addr[31:2], `CBBL_ALIGN_LONG};
                    rem_d   = `CBBL_REM_LONG;
                    write_d = 1'b0;
                end else begin
                    addr_d  = req_addr;
                    rem_d   = (req_size == `CBBL_SIZE_LONG) ?
                              `CBBL_REM_LONG : {1'b0, req_size};
                    write_d = req_write;
                end
                wbuf_d = req_wdata << (8 * (4 - 32'(rem_d)));
            end
            CBBL_START: begin
                // The idle cycle after an abort keeps fetch starts apart.
                if (fetch_q && cache_hit) state_d = CBBL_IDLE;
                else state_d = CBBL_WAIT;
            end
            CBBL_WAIT: begin
                // Wait states are added without limit until an answer.
                if (!ack_port_hi_n || !ack_port_lo_n || !bus_error_n) begin
                    state_d = CBBL_TERM;
                end
                if (!ack_port_hi_n && !ack_port_lo_n) port_d = CBBL_PORT32;
                else if (!ack_port_hi_n) port_d = CBBL_PORT16;
                else port_d = CBBL_PORT8;
            end
            CBBL_TERM: begin
                // Bus error and halt are sampled one clock after the
                // acknowledge so that late assertions still count.
                first_d = 1'b0;
                if (!bus_error_n && !halt_n) begin
                    state_d = CBBL_START;
                end else if (!bus_error_n) begin
                    err_d   = 1'b1;
                    state_d = CBBL_RESP;
                end else begin
                    rbuf_d = acc;
                    wbuf_d = wbuf_q << (8 * 32'(nmov));
                    addr_d = addr_q + 32'(nmov);
                    rem_d  = rem_q - nmov;
                    state_d = (rem_q == nmov) ? CBBL_RESP : CBBL_START;
                end
            end
            CBBL_RESP: if (buf_ready) state_d = CBBL_IDLE;
            default: state_d = CBBL_IDLE;
        endcase
        rdy_d  = (state_d == CBBL_IDLE);
        ecs_d  = (state_d == CBBL_START);
        ocs_d  = (state_d == CBBL_START) && first_d;
        as_d   = (state_d == CBBL_WAIT) || (state_d == CBBL_TERM);
        oe_d   = write_d && (ecs_d || as_d);
        dout_d = wlanes(wbuf_d, addr_d[1:0]);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= CBBL_IDLE;
            port_q  <= CBBL_PORT8;
            addr_q  <= '0;
            rem_q   <= `CBBL_REM_LONG;
            wbuf_q  <= '0;
            rbuf_q  <= '0;
            write_q <= 1'b0;
            fetch_q <= 1'b0;
            first_q <= 1'b0;
            err_q   <= 1'b0;
            req_ready             <= 1'b0;
            addr_strobe_n         <= 1'b1;
            data_strobe_n         <= 1'b1;
            early_cycle_start_n   <= 1'b1;
            operand_cycle_start_n <= 1'b1;
            bus_read              <= 1'b1;
            data_oe               <= 1'b0;
            data_out              <= '0;
        end else begin
            state_q <= state_d;
            port_q  <= port_d;
            addr_q  <= addr_d;
            rem_q   <= rem_d;
            wbuf_q  <= wbuf_d;
            rbuf_q  <= rbuf_d;
            write_q <= write_d;
            fetch_q <= fetch_d;
            first_q <= first_d;
            err_q   <= err_d;
            req_ready             <= rdy_d;
            addr_strobe_n         <= !as_d;
            data_strobe_n         <= !as_d;
            early_cycle_start_n   <= !ecs_d;
            operand_cycle_start_n <= !ocs_d;
            bus_read              <= !write_d;
            data_oe               <= oe_d;
            data_out              <= dout_d;
        end
    end

    assign bus_addr     = addr_q;
    assign size_code_hi = rem_q[1];
    assign size_code_lo = rem_q[0];

    cbbl_resp_buf #(
        .W (`CBBL_RESP_W)
    ) u_resp_buf (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (state_q == CBBL_RESP),
        .in_ready  (buf_ready),
        .in_data   ({err_q, rbuf_q}),
        .out_valid (resp_valid),
        .out_ready (resp_ready),
        .out_data  ({resp_error, resp_data})
    );

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_take_byte;
        req_valid && req_ready && !req_fetch &&
        req_size == `CBBL_SIZE_BYTE;
    endsequence
    sequence s_abort;
        state_q == CBBL_START && fetch_q && cache_hit;
    endsequence

    AST_SIZE_CODE: assert property (
        s_take_byte |=> !early_cycle_start_n &&
        {size_code_hi, size_code_lo} == `CBBL_SIZE_BYTE)
        else $error("byte request did not show byte size code");
    AST_FETCH_ALIGN: assert property (
        req_valid && req_ready && req_fetch |=>
        bus_addr[1:0] == `CBBL_ALIGN_LONG &&
        {size_code_hi, size_code_lo} == `CBBL_SIZE_LONG)
        else $error("fetch not long word aligned");
    AST_WRITE_LANES: assert property (
        !addr_strobe_n && !bus_read |-> data_oe)
        else $error("write cycle without data drive");
    AST_ABORT: assert property (
        s_abort |=> addr_strobe_n [*2])
        else $error("address strobe after cache hit abort");
    AST_ECS_PULSE: assert property (
        $fell(early_cycle_start_n) |=> early_cycle_start_n)
        else $error("early cycle start longer than one clock");
    AST_STROBES: assert property (
        !early_cycle_start_n && !(fetch_q && cache_hit) |=>
        !addr_strobe_n && !data_strobe_n)
        else $error("strobes missing after cycle start");
    AST_MIN_CYCLE: assert property (
        $fell(addr_strobe_n) |-> !addr_strobe_n [*2])
        else $error("bus cycle shorter than three clocks");
    AST_WAIT_HOLD: assert property (
        state_q == CBBL_WAIT && ack_port_hi_n && ack_port_lo_n &&
        bus_error_n |=> !addr_strobe_n && state_q == CBBL_WAIT)
        else $error("cycle ended without acknowledge");
    AST_RETRY: assert property (
        state_q == CBBL_TERM && !bus_error_n && !halt_n |=>
        !early_cycle_start_n && rem_q == $past(rem_q))
        else $error("late bus error with halt did not retry");
    AST_BYTE_COUNT: assert property (
        state_q == CBBL_TERM && bus_error_n && port_q == CBBL_PORT32 &&
        rem_q == `CBBL_REM_LONG && addr_q[1:0] == 2'h1 |=>
        rem_q == 3'h1)
        else $error("misaligned long word moved wrong byte count");
endmodule
`default_nettype wire

// ===== cbbl_slave_model.sv
// Purpose: Slave on the far side of the bus controller.
// Assumes: Port size, wait states and fault mode set by the bench.
// Notes:   Faults hit only the first cycle of an operation.
`timescale 1ns/100ps
`default_nettype none
module cbbl_slave_model
    import cbbl_pkg::*;
(
    input  wire logic        clk,
    input  wire logic [1:0]  port,
    input  wire logic [1:0]  waits,
    input  wire logic [1:0]  mode,
    input  wire logic [31:0] bus_addr,
    input  wire logic        size_code_hi,
    input  wire logic        size_code_lo,
    input  wire logic        bus_read,
    input  wire logic        addr_strobe_n,
    input  wire logic        data_strobe_n,
    input  wire logic        operand_cycle_start_n,
    input  wire logic [31:0] data_out,
    output logic [31:0]      data_in,
    output logic             ack_port_hi_n,
    output logic             ack_port_lo_n,
    output logic             bus_error_n,
    output logic             halt_n
);
    logic [7:0]  mem [256];
    logic [31:0] t;
    logic [2:0]  cnt;
    logic        first;
    int          b, n, i;
    initial begin
        for (i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'h5a;
        {ack_port_hi_n, ack_port_lo_n, bus_error_n, halt_n} = 4'hf;
        data_in = 32'h0;
        cnt = 3'h0;
        first = 1'b0;
    end
    // Released data toggles every cycle so stale bytes never pass.
    always @(negedge clk) begin
        if (addr_strobe_n) begin
            {ack_port_hi_n, ack_port_lo_n, bus_error_n, halt_n} <= 4'hf;
            data_in <= ~data_in;
            if (!operand_cycle_start_n) first <= 1'b1;
            else if (cnt != 3'h0) first <= 1'b0;
            cnt <= 3'h0;
        end else begin
            cnt <= cnt + 3'h1;
            if (cnt == {1'b0, waits}) begin
                if (first && mode == 2'h1) begin
                    bus_error_n <= 1'b0;
                end else if (first && mode == 2'h2) begin
                    bus_error_n <= 1'b0;
                    halt_n <= 1'b0;
                end else begin
                    ack_port_hi_n <= port == CBBL_PORT8;
                    ack_port_lo_n <= port == CBBL_PORT16;
                    b = int'(bus_addr[1:0]) % (1 << port);
                    n = int'({size_code_hi, size_code_lo});
                    if (n == 0) n = 4;
                    if (n > (1 << port) - b) n = (1 << port) - b;
                    t = ~data_in;
                    // Reads fill the whole port, as a cached read expects.
                    for (i = 0; i < (1 << port); i++) begin
                        if (bus_read)
                            t[31-8*i -: 8] = mem[8'(bus_addr[7:0] - b + i)];
                    end
                    for (i = b; i < b + n; i++) begin
                        t[31-8*i -: 8] = mem[8'(bus_addr[7:0] - b + i)];
                        if (!bus_read && !data_strobe_n &&
                            !(first && mode == 2'h3))
                            mem[8'(bus_addr[7:0] - b + i)] <=
                                data_out[31-8*i -: 8];
                    end
                    data_in <= t;
                end
            end else if (first && mode == 2'h3 && cnt == waits + 3'h1) begin
                bus_error_n <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ===== cbbl_bus_ctrl_tb.sv
// Purpose: Self-checking bench of the bus controller.
// Assumes: Slave model answers on the far side.
// Notes:   Random operations after a few corner cases.
`timescale 1ns/100ps
`default_nettype none
module cbbl_bus_ctrl_tb
    import cbbl_pkg::*;
;
    logic        clk, rst, req_valid, req_ready, req_write, req_fetch;
    logic        cache_hit, resp_valid, resp_ready, resp_error, as_prev;
    logic        size_code_hi, size_code_lo, bus_read, addr_strobe_n;
    logic        data_strobe_n, early_cycle_start_n, halt_n, data_oe;
    logic        operand_cycle_start_n, ack_port_hi_n, ack_port_lo_n;
    logic        bus_error_n;
    logic [1:0]  req_size, port, waits, mode;
    logic [31:0] req_addr, req_wdata, resp_data, bus_addr;
    logic [31:0] data_out, data_in;
    logic [7:0]  ref_m [256];
    logic [3:0]  seen [$];
    logic [3:0]  exq [$];
    int          bad_count, checked, seed, t, i;
    initial clk = 1'b0;
    always #2.5 clk = ~clk;
    cbbl_bus_ctrl u_dut (.clk, .rst, .req_valid, .req_ready, .req_addr,
        .req_size, .req_write, .req_wdata, .req_fetch, .cache_hit,
        .resp_valid, .resp_ready, .resp_data, .resp_error, .bus_addr,
        .size_code_hi, .size_code_lo, .bus_read, .addr_strobe_n,
        .data_strobe_n, .early_cycle_start_n, .operand_cycle_start_n,
        .data_out, .data_oe, .data_in, .ack_port_hi_n, .ack_port_lo_n,
        .bus_error_n, .halt_n);
    cbbl_slave_model u_slave (.clk, .port, .waits, .mode, .bus_addr,
        .size_code_hi, .size_code_lo, .bus_read, .addr_strobe_n,
        .data_strobe_n, .operand_cycle_start_n, .data_out, .data_in,
        .ack_port_hi_n, .ack_port_lo_n, .bus_error_n, .halt_n);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic hang;
        bad_count++;
        test_done();
    endtask
    always @(negedge clk) begin
        if (as_prev && !addr_strobe_n) begin
            seen.push_back({size_code_hi, size_code_lo, bus_addr[1:0]});
            chk({data_oe, data_strobe_n}, {!bus_read, 1'b0});
        end
        as_prev = addr_strobe_n;
    end
    task automatic run_op(input logic [31:0] a, input logic [1:0] s,
                          input logic w, f, h, input logic [1:0] p, md);
        logic [31:0] ea, e;
        int          n, r, o, mv, to;
        ea = f ? {a[31:2], 2'h0} : a;
        n = (f || s == 2'h0) ? 4 : int'(s);
        e = 32'h0;
        for (int k = 0; k < n; k++) e = {e[23:0], ref_m[8'(ea + k)]};
        {port, mode, waits} = {p, md, 2'($random(seed))};
        {req_addr, req_size, req_write, req_fetch} = {a, s, w, f};
        req_wdata = $random(seed);
        cache_hit = h;
        req_valid = 1'b1;
        seen.delete();
        exq.delete();
        for (to = 0; to < 99 && req_ready !== 1'b1; to++) @(negedge clk);
        @(negedge clk);
        req_valid = 1'b0;
        if (to == 99) hang();
        r = n;
        o = int'(ea[1:0]);
        while (r > 0) begin
            mv = (1 << p) - o % (1 << p);
            if (mv > r) mv = r;
            exq.push_back({2'(r), 2'(o)});
            r -= mv;
            o = (o + mv) % 4;
        end
        if (md == 2'h2) exq.push_front(exq[0]);
        if (md[0]) exq = exq[0:0];
        for (to = 0; to < 99 && resp_valid !== 1'b1; to++) @(negedge clk);
        if (f && h) begin
            chk(32'(seen.size()), 32'h0);
            chk({31'h0, resp_valid}, 32'h0);
        end else begin
            if (to == 99) hang();
            repeat ($unsigned($random(seed)) % 4) @(negedge clk);
            chk({31'h0, resp_error}, {31'h0, md[0]});
            if (!md[0]) chk(resp_data, e);
            resp_ready = 1'b1;
            @(negedge clk);
            resp_ready = 1'b0;
            if (w && !f && !md[0])
                for (int k = 0; k < n; k++)
                    ref_m[8'(ea + k)] = req_wdata[8*(n-1-k) +: 8];
            chk(32'(seen.size()), 32'(exq.size()));
            foreach (exq[k]) chk({28'h0, seen[k]}, {28'h0, exq[k]});
        end
        t++;
        $display("test %0d done", t);
    endtask
    initial begin
        seed = 32'h7d59;
        {rst, req_valid, req_write, req_fetch, cache_hit, resp_ready} = 6'h20;
        {req_size, port, waits, mode} = 8'h0;
        {req_addr, req_wdata} = 64'h0;
        {as_prev, bad_count, checked, t} = {1'b1, 96'h0};
        for (i = 0; i < 256; i++) ref_m[i] = i[7:0] ^ 8'h5a;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        repeat (2) @(negedge clk);
        run_op(32'h1001, 2'h0, 1'b0, 1'b0, 1'b0, CBBL_PORT32, 2'h0);
        run_op(32'h2005, 2'h0, 1'b1, 1'b0, 1'b0, CBBL_PORT16, 2'h0);
        run_op(32'h2005, 2'h0, 1'b0, 1'b0, 1'b0, CBBL_PORT8, 2'h0);
        run_op(32'h0033, 2'h3, 1'b1, 1'b0, 1'b0, CBBL_PORT32, 2'h0);
        run_op(32'h0043, 2'h2, 1'b0, 1'b0, 1'b1, CBBL_PORT16, 2'h0);
        run_op(32'h0102, 2'h1, 1'b0, 1'b1, 1'b1, CBBL_PORT32, 2'h0);
        run_op(32'h0106, 2'h1, 1'b0, 1'b1, 1'b0, CBBL_PORT8, 2'h0);
        run_op(32'h0051, 2'h0, 1'b1, 1'b0, 1'b0, CBBL_PORT16, 2'h2);
        run_op(32'h0062, 2'h2, 1'b1, 1'b0, 1'b0, CBBL_PORT32, 2'h1);
        run_op(32'h0073, 2'h0, 1'b0, 1'b0, 1'b0, CBBL_PORT32, 2'h3);
        for (i = 0; i < 60; i++)
            run_op($random(seed), 2'($random(seed)), 1'($random(seed)),
                   $unsigned($random(seed)) % 4 == 0, 1'($random(seed)),
                   2'($unsigned($random(seed)) % 3),
                   $unsigned($random(seed)) % 5 == 0 ?
                       2'($random(seed)) : 2'h0);
        test_done();
    end
endmodule
`default_nettype wire
